/* File: rtl/icu_ctrl.sv */
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module icu_ctrl
  import icu_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire logic              ext_pin_in,
  input  wire icu_bank_type      periph_event_in,
  input  wire logic              core_halted_in,
  input  wire logic              return_from_isr_in,
  input  wire icu_ctx_type       core_ctx_in,
  output icu_core_cmd_type       core_cmd_out,
  output logic      [14:0]       vector_addr_out,
  output icu_ctx_type            ctx_restore_out
);

  // ********************************************************************
  // declarations
  // ********************************************************************
  logic [1:0]       qph_reg;
  logic [1:0]       qph_next;
  icu_state_type    state_reg;
  icu_state_type    state_next;
  logic [7:0]       ctrl_reg;
  logic [7:0]       ctrl_next;
  icu_bank_type     en_reg;
  icu_bank_type     en_next;
  icu_bank_type     req_reg;
  icu_bank_type     req_next;
  icu_bank_type     ev_all;
  logic [ICU_BANKS-1:0] wr_en;
  logic [ICU_BANKS-1:0] wr_req;
  logic             dp_wr_reg;
  logic [11:0]      dp_idx_reg;
  logic [31:0]      hrdata_reg;
  logic             hready_reg;
  icu_core_cmd_type cmd_reg;
  icu_core_cmd_type cmd_next;
  logic [14:0]      vector_reg;
  icu_ctx_type      restore_reg;
  icu_ctx_type      ctx_saved;
  logic             ext_edge;

  // ********************************************************************
  // quarter-phase sequencing
  // ********************************************************************
  // one instruction cycle is ICU_Q_PER_TCY clocks; decisions happen only
  // on the first quarter so latency never depends on the opcode length
  wire tick = (qph_reg == ICU_Q1);
  assign qph_next = (qph_reg == ICU_Q_LAST) ? ICU_Q1 : qph_reg + 2'h1;

  // ********************************************************************
  // bus slave
  // ********************************************************************
  // zero wait state; unmapped addresses read zero and ignore writes
  wire        ap_valid = hsel_in & htrans_in[1] & hready_in;
  wire        ap_hi_ok = (haddr_in[31:14] == 18'h0);
  wire [11:0] ap_idx   = haddr_in[13:2];
  wire [7:0]  wdata8   = hwdata_in[7:0];
  wire        wr_ctrl  = dp_wr_reg & (dp_idx_reg == ICU_IDX_CTRL);

  // ********************************************************************
  // external edge source
  // ********************************************************************
  icu_edge_detect u_edge (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .pin_in        (ext_pin_in),
    .rising_sel_in (ctrl_reg[ICU_EDGE_BIT]),
    .edge_out      (ext_edge)
  );

  // ********************************************************************
  // enable and request banks
  // ********************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < ICU_BANKS; gi++) begin : g_bank
      assign wr_en[gi]  = dp_wr_reg & (dp_idx_reg == ICU_IDX_EN[gi]);
      assign wr_req[gi] = dp_wr_reg & (dp_idx_reg == ICU_IDX_REQ[gi]);
      if (gi == 0) begin : g_ext
        // edge lands on any clock; the next first quarter sees it
        assign ev_all[gi] = periph_event_in[gi] |
                            {7'h00, ext_edge};
      end else begin : g_plain
        assign ev_all[gi] = periph_event_in[gi];
      end
      assign en_next[gi] = wr_en[gi] ? (wdata8 & ICU_BANK_MASK[gi])
                                     : en_reg[gi];
      // an event in the clearing cycle survives the write
      assign req_next[gi] = ((wr_req[gi] ? wdata8 : req_reg[gi]) |
                             ev_all[gi]) & ICU_BANK_MASK[gi];
    end
  endgenerate

  // ********************************************************************
  // request combination
  // ********************************************************************
  wire global_irq_enable  = ctrl_reg[ICU_GIE_BIT];
  wire peripheral_irq_enable = ctrl_reg[ICU_PERIPHERAL_IRQ_ENABLE_BIT];
  wire prim_pend = |(req_reg[0] & en_reg[0]);
  wire per_pend  = |((req_reg[1] & en_reg[1]) |
                     (req_reg[2] & en_reg[2]));
  wire irq_pending = prim_pend | (per_pend & peripheral_irq_enable);
  wire irq_req     = irq_pending & global_irq_enable;

  // ********************************************************************
  // take sequencer
  // ********************************************************************
  wire take_run  = tick & (state_reg == ICU_IDLE) & irq_req &
                   ~core_halted_in;
  wire take_wake = tick & (state_reg == ICU_WAKE) & irq_req;
  wire go_wake   = tick & (state_reg == ICU_IDLE) & irq_req &
                   core_halted_in;
  wire enter_flush  = take_run | take_wake;
  wire enter_vector = tick & (state_reg == ICU_FLUSH);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ICU_IDLE: begin
        if (go_wake) begin
          state_next = ICU_WAKE;
        end else if (take_run) begin
          state_next = ICU_FLUSH;
        end
      end
      ICU_WAKE: begin
        // one instruction after the halt runs before any branch
        if (take_wake) begin
          state_next = ICU_FLUSH;
        end else if (tick) begin
          state_next = ICU_IDLE;
        end
      end
      ICU_FLUSH: begin
        if (tick) begin
          state_next = ICU_VECTOR;
        end
      end
      ICU_VECTOR: begin
        if (tick) begin
          state_next = ICU_IDLE;
        end
      end
      default: begin
        state_next = ICU_IDLE;
      end
    endcase
  end

  // ********************************************************************
  // control register
  // ********************************************************************
  // hardware clear on take outranks a same-cycle software write of one
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wdata8 & ICU_CTRL_MASK;
    end
    if (return_from_isr_in) begin
      ctrl_next[ICU_GIE_BIT] = 1'b1;
    end
    if (enter_flush) begin
      ctrl_next[ICU_GIE_BIT] = 1'b0;
    end
  end

  // ********************************************************************
  // core commands
  // ********************************************************************
  always_comb begin
    cmd_next         = '0;
    cmd_next.flush   = enter_flush;
    cmd_next.push_pc = enter_flush;
    cmd_next.pc_load = enter_vector;
    cmd_next.pop_pc  = return_from_isr_in;
    cmd_next.restore = return_from_isr_in;
    cmd_next.wake    = core_halted_in & irq_pending;
  end

  icu_ctx_shadow u_shadow (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .save_in    (enter_flush),
    .ctx_in     (core_ctx_in),
    .ctx_out    (ctx_saved)
  );

  // ********************************************************************
  // read mux
  // ********************************************************************
  // reads see next values so a write just before a read is returned
  wire [7:0] rd_byte =
    !ap_hi_ok                  ? 8'h00 :
    (ap_idx == ICU_IDX_CTRL)   ? ctrl_next :
    (ap_idx == ICU_IDX_EN[0])  ? en_next[0] :
    (ap_idx == ICU_IDX_EN[1])  ? en_next[1] :
    (ap_idx == ICU_IDX_EN[2])  ? en_next[2] :
    (ap_idx == ICU_IDX_REQ[0]) ? req_next[0] :
    (ap_idx == ICU_IDX_REQ[1]) ? req_next[1] :
    (ap_idx == ICU_IDX_REQ[2]) ? req_next[2] : 8'h00;
  wire ap_read = ap_valid & ~hwrite_in;

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      qph_reg    <= ICU_Q1;
      state_reg  <= ICU_IDLE;
      ctrl_reg   <= ICU_CTRL_RESET;
      en_reg     <= ICU_BANK_RESET;
      req_reg    <= ICU_BANK_RESET;
      cmd_reg    <= '0;
      vector_reg <= ICU_VECTOR_RESET;
      restore_reg <= '0;
    end else begin
      qph_reg    <= qph_next;
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      en_reg     <= en_next;
      req_reg    <= req_next;
      cmd_reg    <= cmd_next;
      if (enter_vector) begin
        vector_reg <= ICU_VECTOR_ADDR;
      end
      if (return_from_isr_in) begin
        restore_reg <= ctx_saved;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dp_wr_reg  <= 1'b0;
      dp_idx_reg <= 12'h000;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
    end else begin
      dp_wr_reg  <= ap_valid & hwrite_in & ap_hi_ok;
      dp_idx_reg <= ap_idx;
      hrdata_reg <= ap_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      hready_reg <= 1'b1;
    end
  end

  assign hrdata_out      = hrdata_reg;
  assign hreadyout_out   = hready_reg;
  assign hresp_out       = 1'b0;
  assign core_cmd_out    = cmd_reg;
  assign vector_addr_out = vector_reg;
  assign ctx_restore_out = restore_reg;

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_RESET_OFF: assert property (disable iff (1'b0)
    sys_rst_in |=> !ctrl_reg[ICU_GIE_BIT] && en_reg == '0)
    else $error("interrupts enabled after reset");
  AST_NO_TAKE_OFF: assert property (
    cmd_reg.flush |-> !$past(irq_pending & global_irq_enable) == 1'b0)
    else $error("take without enables");
  AST_FLAG_SET: assert property ((ev_all != '0) |=>
    ((req_reg & $past(ev_all & ICU_BANK_MASK)) ==
     $past(ev_all & ICU_BANK_MASK)))
    else $error("event did not set its flag");
  AST_TAKE_EFFECT: assert property (enter_flush |=>
    cmd_reg.flush && cmd_reg.push_pc && !ctrl_reg[ICU_GIE_BIT])
    else $error("take effects missing");
  AST_VECTOR_LOAD: assert property (cmd_reg.flush |-> ##4
    (cmd_reg.pc_load && vector_addr_out == ICU_VECTOR_ADDR))
    else $error("vector not loaded");
  AST_SHADOW_SAVE: assert property (cmd_reg.flush |->
    ctx_saved.working == $past(core_ctx_in.working) &&
    ctx_saved.status == ($past(core_ctx_in.status) & ICU_STATUS_KEEP))
    else $error("context not shadowed");
  AST_PEND_TAKEN: assert property (take_run |=> cmd_reg.flush)
    else $error("pending request not taken");
  AST_RETURN: assert property ((return_from_isr_in && !enter_flush) |=>
    ctrl_reg[ICU_GIE_BIT] && cmd_reg.pop_pc && cmd_reg.restore)
    else $error("return incomplete");
  AST_Q1_ONLY: assert property (enter_flush |-> qph_reg == ICU_Q1)
    else $error("take outside first quarter");
  AST_LATENCY: assert property (take_run |-> ##5 cmd_reg.pc_load)
    else $error("latency wrong");
  AST_WAKE: assert property ((core_halted_in && irq_pending) |=>
    cmd_reg.wake)
    else $error("no wake");
  AST_WAKE_FIRST: assert property (go_wake |=>
    state_reg == ICU_WAKE && !cmd_reg.flush)
    else $error("branch before post-halt instruction");

  COV_TAKE:   cover property (take_run ##5 cmd_reg.pc_load);
  COV_RETURN: cover property (cmd_reg.pc_load ##[1:50] return_from_isr_in);
  COV_WAKE:   cover property (go_wake ##4 enter_flush);

endmodule : icu_ctrl

/* File: rtl/icu_ctx_shadow.sv */
`timescale 1ns/1ps
module icu_ctx_shadow
  import icu_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         save_in,
  input  wire icu_ctx_type  ctx_in,
  output icu_ctx_type       ctx_out
);

  icu_ctx_type shadow_reg;
  icu_ctx_type shadow_next;

  // ********************************************************************
  // capture
  // ********************************************************************
  // the two power flags are not shadowed: a return must not undo them
  always_comb begin
    shadow_next = shadow_reg;
    if (save_in) begin
      shadow_next = ctx_in;
      shadow_next.status = ctx_in.status & ICU_STATUS_KEEP;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      shadow_reg <= '0;
    end else begin
      shadow_reg <= shadow_next;
    end
  end

  assign ctx_out = shadow_reg;

endmodule : icu_ctx_shadow

/* File: rtl/icu_edge_detect.sv */
`timescale 1ns/1ps
module icu_edge_detect
  import icu_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  input  wire logic rising_sel_in,
  output logic      edge_out
);

  logic prev_reg;
  logic armed_reg;
  logic edge_reg;

  // ********************************************************************
  // edge select
  // ********************************************************************
  // armed after the first sample so a pin already low or high at reset
  // release does not fake an edge
  wire rise_seen = pin_in & ~prev_reg;
  wire fall_seen = ~pin_in & prev_reg;
  wire edge_next = armed_reg & (rising_sel_in ? rise_seen : fall_seen);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prev_reg  <= 1'b0;
      armed_reg <= 1'b0;
      edge_reg  <= 1'b0;
    end else begin
      prev_reg  <= pin_in;
      armed_reg <= 1'b1;
      edge_reg  <= edge_next;
    end
  end

  assign edge_out = edge_reg;

  AST_EDGE_SEL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (armed_reg && rising_sel_in && pin_in && !prev_reg) |=> edge_reg)
    else $error("selected edge not detected");

endmodule : icu_edge_detect

/* File: rtl/icu_pkg.sv */
package icu_pkg;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 100;
  // instruction_cycle_time
  localparam int ICU_TCY_NS    = 400;
  localparam int ICU_Q_PER_TCY = ICU_TCY_NS / CLK_PERIOD_NS;
  localparam logic [1:0] ICU_Q1 = 2'h0;
  localparam logic [1:0] ICU_Q_LAST = 2'(ICU_Q_PER_TCY - 1);

  // ********************************************************************
  // register indices (byte address is four times the index)
  // ********************************************************************
  localparam int ICU_BANKS = 3;
  localparam logic [11:0] ICU_IDX_CTRL = 12'h00B;
  localparam logic [ICU_BANKS-1:0][11:0] ICU_IDX_EN =
    {12'h718, 12'h717, 12'h716};
  localparam logic [ICU_BANKS-1:0][11:0] ICU_IDX_REQ =
    {12'h70E, 12'h70D, 12'h70C};

  // ********************************************************************
  // field layout and reset values
  // ********************************************************************
  typedef logic [ICU_BANKS-1:0][7:0] icu_bank_type;
  localparam icu_bank_type ICU_BANK_MASK = {8'hE0, 8'hFF, 8'h31};
  localparam int ICU_GIE_BIT  = 7;
  localparam int ICU_PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int ICU_EDGE_BIT = 0;
  localparam int ICU_EXT_BIT  = 0;
  localparam logic [7:0] ICU_CTRL_MASK  = 8'hC1;
  localparam logic [7:0] ICU_CTRL_RESET = 8'h01;
  localparam icu_bank_type ICU_BANK_RESET = '0;
  // status without timeout_flag (bit 4) and power_down_flag (bit 3)
  localparam logic [7:0] ICU_STATUS_KEEP = 8'hE7;
  localparam logic [14:0] ICU_VECTOR_ADDR = 15'h0004;
  localparam logic [14:0] ICU_VECTOR_RESET = 15'h0000;

  // ********************************************************************
  // carriers and states
  // ********************************************************************
  typedef struct packed {
    logic [7:0]  working;
    logic [7:0]  status;
    logic [5:0]  bank_select;
    logic [15:0] pointer0;
    logic [15:0] pointer1;
    logic [6:0]  pc_high;
  } icu_ctx_type;

  typedef struct packed {
    logic flush;
    logic push_pc;
    logic pc_load;
    logic pop_pc;
    logic restore;
    logic wake;
  } icu_core_cmd_type;

  typedef enum logic [1:0] {
    ICU_IDLE   = 2'h0,
    ICU_FLUSH  = 2'h1,
    ICU_VECTOR = 2'h3,
    ICU_WAKE   = 2'h2
  } icu_state_type;

endpackage : icu_pkg

/* File: testbench/icu_core_model.sv */
`timescale 1ns/1ps
module icu_core_model
  import icu_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire icu_core_cmd_type cmd_in,
  output icu_ctx_type           ctx_out,
  output icu_ctx_type           saved_out,
  output int                    depth_out
);
  icu_ctx_type prev_reg;

  // ****
  // core sequencer
  // ****
  // context moves every cycle so a late capture shows up
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctx_out   <= '0;
      prev_reg  <= '0;
      saved_out <= '0;
      depth_out <= 0;
    end else begin
      ctx_out  <= icu_ctx_type'(ctx_out * 61'h5 + 61'h1B);
      prev_reg <= ctx_out;
      if (cmd_in.flush) begin
        saved_out        <= prev_reg;
        saved_out.status <= prev_reg.status & ICU_STATUS_KEEP;
      end
      depth_out <= depth_out + int'(cmd_in.push_pc)
                 - int'(cmd_in.pop_pc);
    end
  end
endmodule : icu_core_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import icu_pkg::*;
;
  logic             clk_in = 1'b0;
  logic             sys_rst_in = 1'b1;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic [1:0]       htrans = 2'h0;
  logic [31:0]      haddr = '0;
  logic [31:0]      hwdata = '0;
  logic [31:0]      hrdata;
  logic             hready;
  logic             hresp;
  logic             ext_pin = 1'b0;
  logic             halted = 1'b0;
  logic             ret = 1'b0;
  icu_bank_type     ev = '0;
  icu_ctx_type      ctx;
  icu_ctx_type      saved;
  icu_ctx_type      ctx_rs;
  icu_ctx_type      rs_cap;
  icu_core_cmd_type cmd;
  logic [14:0]      vec;
  logic [15:0]      lf = 16'h004D;
  int               depth;
  int               error_cnt, cmp_count, cyc, t_fl, t_ld, t_ev;
  int               takes, m_takes, m_ctrl;
  int               m_en[3], m_req[3];

  icu_ctrl u_icu_ctrl (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ext_pin_in(ext_pin), .periph_event_in(ev),
    .core_halted_in(halted), .return_from_isr_in(ret),
    .core_ctx_in(ctx), .core_cmd_out(cmd), .vector_addr_out(vec),
    .ctx_restore_out(ctx_rs)
  );

  icu_core_model u_icu_core_model (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd),
    .ctx_out(ctx), .saved_out(saved), .depth_out(depth)
  );

  always #50 clk_in = ~clk_in;

  // ****
  // monitor and timeout
  // ****
  always @(posedge clk_in) begin
    cyc++;
    if (cmd.flush === 1'b1) begin
      t_fl = cyc;
      takes++;
    end
    if (cmd.pc_load === 1'b1) t_ld = cyc;
    if (ev !== '0) t_ev = cyc;
    if (cmd.restore === 1'b1) rs_cap = ctx_rs;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // ****
  // helpers
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  function automatic bit pend_m();
    bit b;
    b = (m_req[0] & m_en[0]) != 0;
    if (m_ctrl[6]) b |= ((m_req[1] & m_en[1]) | (m_req[2] & m_en[2])) != 0;
    return b;
  endfunction : pend_m

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {18'h0, idx, 2'h0};
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask : ahb

  task automatic rdc(input logic [11:0] idx, input int e);
    logic [31:0] rd;
    ahb(1'b0, idx, '0, rd);
    chk("reg", e, rd);
  endtask : rdc

  task automatic set_ctrl(input logic [7:0] d);
    logic [31:0] rd;
    ahb(1'b1, ICU_IDX_CTRL, {24'h0, d}, rd);
    m_ctrl = int'(d & ICU_CTRL_MASK);
  endtask : set_ctrl

  task automatic set_en(input int i, input logic [7:0] d);
    logic [31:0] rd;
    ahb(1'b1, ICU_IDX_EN[i], {24'h0, d}, rd);
    m_en[i] = int'(d & ICU_BANK_MASK[i]);
  endtask : set_en

  task automatic set_req(input int i, input logic [7:0] d);
    logic [31:0] rd;
    ahb(1'b1, ICU_IDX_REQ[i], {24'h0, d}, rd);
    m_req[i] = int'(d & ICU_BANK_MASK[i]);
  endtask : set_req

  task automatic pulse(input icu_bank_type p);
    @(posedge clk_in);
    ev <= p;
    @(posedge clk_in);
    ev <= '0;
    for (int i = 0; i < 3; i++) m_req[i] |= int'(p[i] & ICU_BANK_MASK[i]);
  endtask : pulse

  // take is predicted once the enables and flags have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    if (m_ctrl[7] && pend_m()) begin
      m_takes++;
      m_ctrl[7] = 1'b0;
    end
    chk("takes", m_takes, takes);
  endtask : settle

  task automatic do_ret();
    @(posedge clk_in);
    ret <= 1'b1;
    m_ctrl[7] = 1'b1;
    @(posedge clk_in);
    ret <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : do_ret

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // ****
  // main sequence
  // ****
  initial begin
    m_ctrl = 1;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdc(ICU_IDX_CTRL, m_ctrl);
    for (int i = 0; i < 3; i++) begin
      rdc(ICU_IDX_EN[i], 0);
      rdc(ICU_IDX_REQ[i], 0);
    end
    rdc(12'h123, 0);
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      set_en(k % 3, lf[7:0]);
      rdc(ICU_IDX_EN[k % 3], m_en[k % 3]);
    end
    lf = lfsr(lf);
    set_ctrl(lf[7:0] & 8'h7F);
    rdc(ICU_IDX_CTRL, m_ctrl);
    lf = lfsr(lf);
    pulse({lf[15:8], lf[7:0], ~lf[7:0]});
    for (int i = 0; i < 3; i++) rdc(ICU_IDX_REQ[i], m_req[i]);
    settle(12);
    halted <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("wake", pend_m(), cmd.wake);
    halted <= 1'b0;
    settle(12);
    for (int i = 0; i < 3; i++) begin
      set_req(i, 8'h00);
      set_en(i, 8'h00);
      rdc(ICU_IDX_REQ[i], 0);
    end
    // primary source vectors without the peripheral enable
    set_en(0, 8'h10);
    set_ctrl(8'h81);
    pulse({16'h0, 8'h10});
    settle(16);
    chk("latency", 1, (t_ld - t_ev) <= 16);
    chk("load_gap", 4, t_ld - t_fl);
    chk("vector", ICU_VECTOR_ADDR, vec);
    chk("depth", 1, depth);
    rdc(ICU_IDX_CTRL, m_ctrl);
    rdc(ICU_IDX_REQ[0], m_req[0]);
    set_req(0, 8'h00);
    do_ret();
    chk("restore", saved, rs_cap);
    chk("depth", 0, depth);
    rdc(ICU_IDX_CTRL, m_ctrl);
    // halted core: one more instruction runs before the branch
    halted <= 1'b1;
    pulse({16'h0, 8'h10});
    settle(20);
    chk("wake", 1, cmd.wake);
    chk("wake_gap", 1, (t_fl - t_ev) >= 6);
    chk("load_gap", 4, t_ld - t_fl);
    halted <= 1'b0;
    set_req(0, 8'h00);
    do_ret();
    chk("depth", 0, depth);
    // banked source: held off by each missing enable, then taken
    set_en(1, 8'h01);
    set_ctrl(8'h41);
    pulse({8'h0, 8'h01, 8'h0});
    settle(12);
    set_ctrl(8'h81);
    settle(12);
    set_ctrl(8'hC1);
    settle(16);
    set_req(1, 8'h00);
    do_ret();
    chk("depth", 0, depth);
    for (int s = 1; s >= 0; s--) begin
      set_ctrl(8'(s));
      for (int l = 1; l >= 0; l--) begin
        @(posedge clk_in);
        ext_pin <= 1'(l);
        repeat (3) @(posedge clk_in);
        rdc(ICU_IDX_REQ[0], int'(l == s));
        set_req(0, 8'h00);
      end
    end
    close_out();
  end
endmodule : tb_top
